// ### src/ccs_core.sv
// What this block does
// - 10-bit program counter, plus one per instruction
// - reset starts at 000h, interrupts at 001h, or 200h and 201h with reuse on
// - call and jump load all ten bits
// - returns restore counter from stack top, pop
// - counter low writes keep upper two bits
// - four-deep ten-bit stack, push on call/interrupt
// - option bit makes pin falling edge reset
// - pin reset keeps timeout/powerdown, watchdog reset keeps powerdown and sets timeout
// - hold reset while supply below threshold
// - code protection refuses external program readout
// - write-only plane written only by store instruction
// - indirect window accesses register pointed to
// - subtraction carries mean no borrow
// - flag-updating write to status keeps flags
// - status resets zero, upper bits read zero
// - timeout and powerdown set and cleared by events
// - zero, nibble carry and carry flag meanings
// - eight sources, pending set regardless of enable
// - enabled pending interrupt inserts call to 001, or 201 with reuse on
// - nesting block clears one instruction after return
// - undervoltage field selects threshold and mode
// - protect and reuse bits are active low
`timescale 1ns/1ps
`default_nettype none
module ccs_core
  import ccs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [13:0] rom_data,
  output logic [PC_W-1:0] prog_addr_q,
  input wire logic [13:0] config_word,
  input wire logic port_a_bit_seven,
  input wire logic supply_below_2v1,
  input wire logic supply_below_2v9,
  input wire logic watchdog_timeout,
  input wire logic [7:0] irq_event,
  input wire logic [PC_W-1:0] readout_addr,
  output logic readout_denied_q,
  output logic wo_plane_wr_q,
  output logic [5:0] wo_plane_addr_q,
  output logic [7:0] wo_plane_data_q,
  output logic watchdog_clear_q,
  output logic sleeping_q,
  output logic pa7_gpio_q,
  output logic core_reset_q
);
  ccs_state_t state_q, state_d;
  logic [PC_W-1:0] pc_d, push_addr, stack_top, vec_base;
  logic [13:0] ir_q, ir_d, cfg_q;
  logic [7:0] w_q, w_d, ptr_q, ptr_d, pend_q, pend_d, en_q, en_d;
  logic [7:0] rd, alu_b, alu_res, wdata, wo_data_d;
  logic [7:0] ram_q [RAM_DEPTH];
  logic [7:0] ram_d [RAM_DEPTH];
  logic [4:0] st_q, st_d;
  logic [5:0] ram_idx, wo_addr_d;
  logic [6:0] eff;
  logic [3:0] op;
  logic iflag_q, iflag_d, iclr_q, iclr_d, pin_q, cfg_ok_q;
  logic push, pop, wen, to_w, fz, fdc, fc, alu_z, alu_dc, alu_c;
  logic uv_low, pin_fall, soft_rst, irq_go, exec, wo_wr_d, kick_d, deny_d;
  ccs_alu_op_t alu_op;

  assign op = ir_q[13:10];
  assign eff = (ir_q[6:0] == FA_INDIRECT) ? ptr_q[6:0] : ir_q[6:0];
  assign vec_base = cfg_q[CFG_REUSE] ? RESET_VEC : REUSE_BASE;
  assign pin_fall = cfg_q[CFG_XRST] && pin_q && !port_a_bit_seven;
  assign soft_rst = pin_fall || watchdog_timeout || uv_low;
  assign irq_go = |(pend_q & en_q);
  assign exec = (state_q == CCS_ST_EXEC) && !soft_rst;

  always_comb
  begin
    unique case (cfg_q[CFG_UV_HI:CFG_UV_LO])
      UV_2V1_ALWAYS: uv_low = supply_below_2v1;
      UV_2V1_RUN: uv_low = supply_below_2v1 && (state_q != CCS_ST_SLEEP);
      UV_2V9: uv_low = supply_below_2v9;
      UV_OFF: uv_low = 1'b0;
    endcase
  end

  // protected area is the first half while the second half is still blank
  always_comb
  begin
    if (cfg_q[CFG_PROTECT])
      deny_d = 1'b0;
    else if (cfg_q[CFG_REUSE])
      deny_d = readout_addr < REUSE_BASE;
    else
      deny_d = readout_addr < RESERVED_LO;
  end

  // file read; the indirect window itself holds nothing
  always_comb
  begin
    ram_idx = 6'(eff - FA_RAM_LO);
    if (eff == FA_PC_LOW)
      rd = prog_addr_q[7:0];
    else if (eff == FA_STATUS)
      rd = {3'h0, st_q};
    else if (eff == FA_POINTER)
      rd = ptr_q;
    else if (eff == FA_IRQ_PEND)
      rd = pend_q;
    else if (eff == FA_IRQ_EN)
      rd = en_q;
    else if (eff >= FA_RAM_LO && eff <= FA_RAM_HI)
      rd = ram_q[ram_idx];
    else
      rd = 8'h00;
  end

  ccs_alu u_alu (
    .op(alu_op),
    .w_in(w_q),
    .b_in(alu_b),
    .carry_in(st_q[ST_C]),
    .res(alu_res),
    .z(alu_z),
    .dc(alu_dc),
    .c(alu_c)
  );

  ccs_stack u_stack (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .push(push),
    .pop(pop),
    .push_addr(push_addr),
    .top(stack_top)
  );

  always_comb
  begin
    state_d = state_q;
    pc_d = prog_addr_q;
    ir_d = ir_q;
    w_d = w_q;
    st_d = st_q;
    ptr_d = ptr_q;
    pend_d = pend_q;
    en_d = en_q;
    iflag_d = iflag_q;
    iclr_d = iclr_q;
    ram_d = ram_q;
    wo_wr_d = 1'b0;
    wo_addr_d = wo_plane_addr_q;
    wo_data_d = wo_plane_data_q;
    kick_d = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    push_addr = prog_addr_q + 10'h001;
    alu_op = CCS_ALU_PASS;
    alu_b = rd;
    fz = 1'b0;
    fdc = 1'b0;
    fc = 1'b0;
    wen = 1'b0;
    to_w = 1'b0;
    unique case (state_q)
      CCS_ST_HOLD:
        if (cfg_ok_q)
        begin
          state_d = CCS_ST_FETCH;
          pc_d = vec_base;
        end
      CCS_ST_FETCH:
        if (irq_go && !iflag_q)
        begin
          push = 1'b1;
          push_addr = prog_addr_q;
          pc_d = vec_base + IRQ_VEC;
          iflag_d = 1'b1;
        end
        else
        begin
          ir_d = rom_data;
          state_d = CCS_ST_EXEC;
        end
      CCS_ST_EXEC:
      begin
        state_d = CCS_ST_FETCH;
        pc_d = prog_addr_q + 10'h001;
        if (iclr_q)
        begin
          iflag_d = 1'b0;
          iclr_d = 1'b0;
        end
        unique case (op)
          OP_MISC:
            unique case (ir_q[2:0])
              SUB_RET, SUB_RETURN_FROM_INTERRUPT:
              begin
                pc_d = stack_top;
                pop = 1'b1;
                iclr_d = (ir_q[2:0] == SUB_RETURN_FROM_INTERRUPT);
              end
              SUB_SLEEP:
              begin
                state_d = CCS_ST_SLEEP;
                st_d[ST_PD] = 1'b1;
                st_d[ST_TO] = 1'b0;
              end
              SUB_KICK:
              begin
                kick_d = 1'b1;
                st_d[ST_PD] = 1'b0;
                st_d[ST_TO] = 1'b0;
              end
              default:
                kick_d = 1'b0;
            endcase
          OP_WOSTORE:
          begin
            wo_wr_d = 1'b1;
            wo_addr_d = ir_q[5:0];
            wo_data_d = w_q;
          end
          OP_MOVWF: wen = 1'b1;
          OP_MOVFW:
          begin
            to_w = 1'b1;
            fz = 1'b1;
          end
          OP_ADDWF, OP_SUBWF:
          begin
            alu_op = (op == OP_ADDWF) ? CCS_ALU_ADD : CCS_ALU_SUB;
            fz = 1'b1;
            fdc = 1'b1;
            fc = 1'b1;
          end
          OP_ANDWF, OP_IORWF, OP_XORWF:
          begin
            alu_op = (op == OP_ANDWF) ? CCS_ALU_AND :
                     (op == OP_IORWF) ? CCS_ALU_OR : CCS_ALU_XOR;
            fz = 1'b1;
          end
          OP_RRF, OP_RLF:
          begin
            alu_op = (op == OP_RRF) ? CCS_ALU_RR : CCS_ALU_RL;
            fc = 1'b1;
          end
          OP_JUMP: pc_d = ir_q[9:0];
          OP_CALL:
          begin
            pc_d = ir_q[9:0];
            push = 1'b1;
          end
          OP_RETURN_WITH_LITERAL:
          begin
            pc_d = stack_top;
            pop = 1'b1;
            w_d = ir_q[7:0];
          end
          OP_MOVLW: w_d = ir_q[7:0];
          OP_ANDLW:
          begin
            alu_op = CCS_ALU_AND;
            alu_b = ir_q[7:0];
            to_w = 1'b1;
            fz = 1'b1;
          end
        endcase
        if (op != OP_MOVWF && (fz || fc) && op != OP_MOVFW && op != OP_ANDLW)
        begin
          wen = ir_q[7];
          to_w = !ir_q[7];
        end
        if (to_w)
          w_d = alu_res;
      end
      CCS_ST_SLEEP:
        if (irq_go)
          state_d = CCS_ST_FETCH;
    endcase
    wdata = (op == OP_MOVWF) ? w_q : alu_res;
    if (wen)
    begin
      if (eff == FA_PC_LOW)
        pc_d = {prog_addr_q[9:8], wdata};
      else if (eff == FA_STATUS && !(fz || fdc || fc))
        st_d[2:0] = wdata[2:0];
      else if (eff == FA_POINTER)
        ptr_d = wdata;
      else if (eff == FA_IRQ_PEND)
        pend_d = wdata;
      else if (eff == FA_IRQ_EN)
        en_d = wdata;
      else if (eff >= FA_RAM_LO && eff <= FA_RAM_HI)
        ram_d[ram_idx] = wdata;
    end
    if (fz)
      st_d[ST_Z] = alu_z;
    if (fdc)
      st_d[ST_DC] = alu_dc;
    if (fc)
      st_d[ST_C] = alu_c;
    pend_d = pend_d | irq_event;
    if (soft_rst)
    begin
      state_d = uv_low ? CCS_ST_HOLD : CCS_ST_FETCH;
      pc_d = vec_base;
      ir_d = '0;
      w_d = '0;
      ptr_d = '0;
      pend_d = '0;
      en_d = '0;
      iflag_d = 1'b0;
      iclr_d = 1'b0;
      wo_wr_d = 1'b0;
      kick_d = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      st_d = {st_q[ST_TO:ST_PD], 3'h0};
      if (uv_low)
        st_d[ST_TO:ST_PD] = 2'b00;
      else if (watchdog_timeout)
        st_d[ST_TO] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= CCS_ST_HOLD;
      prog_addr_q <= RESET_VEC;
      ir_q <= '0;
      w_q <= '0;
      st_q <= STATUS_RESET;
      ptr_q <= '0;
      pend_q <= '0;
      en_q <= '0;
      iflag_q <= 1'b0;
      iclr_q <= 1'b0;
      for (int i = 0; i < RAM_DEPTH; i++)
        ram_q[i] <= '0;
      cfg_q <= CFG_RESET;
      cfg_ok_q <= 1'b0;
      pin_q <= 1'b1;
      wo_plane_wr_q <= 1'b0;
      wo_plane_addr_q <= '0;
      wo_plane_data_q <= '0;
      watchdog_clear_q <= 1'b0;
      sleeping_q <= 1'b0;
      pa7_gpio_q <= 1'b1;
      core_reset_q <= 1'b1;
      readout_denied_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      prog_addr_q <= pc_d;
      ir_q <= ir_d;
      w_q <= w_d;
      st_q <= st_d;
      ptr_q <= ptr_d;
      pend_q <= pend_d;
      en_q <= en_d;
      iflag_q <= iflag_d;
      iclr_q <= iclr_d;
      ram_q <= ram_d;
      cfg_q <= config_word;
      cfg_ok_q <= 1'b1;
      pin_q <= port_a_bit_seven;
      wo_plane_wr_q <= wo_wr_d;
      wo_plane_addr_q <= wo_addr_d;
      wo_plane_data_q <= wo_data_d;
      watchdog_clear_q <= kick_d;
      sleeping_q <= (state_d == CCS_ST_SLEEP);
      pa7_gpio_q <= cfg_q[CFG_XRST] | port_a_bit_seven;
      core_reset_q <= soft_rst || (state_d == CCS_ST_HOLD);
      readout_denied_q <= deny_d;
    end
  end

  a_pc_advance: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == OP_MOVLW |=> prog_addr_q == $past(prog_addr_q) + 10'h001)
    else $error("pc did not advance by one");
  a_call_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == OP_CALL |=> prog_addr_q == $past(ir_q[9:0]))
    else $error("call target not loaded");
  a_irq_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_q == CCS_ST_FETCH && irq_go && !iflag_q && !soft_rst
    |=> prog_addr_q == $past(vec_base) + IRQ_VEC && iflag_q)
    else $error("interrupt entry wrong");
  a_ret_restore: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && (op == OP_RETURN_WITH_LITERAL || (op == OP_MISC && ir_q[2:0] == SUB_RET))
    |=> prog_addr_q == $past(stack_top))
    else $error("return address not restored");
  a_pcl_keep_hi: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == OP_MOVWF && eff == FA_PC_LOW
    |=> prog_addr_q == {$past(prog_addr_q[9:8]), $past(w_q)})
    else $error("pc upper bits changed");
  a_ext_pin_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    pin_fall && !uv_low |=> state_q == CCS_ST_FETCH && prog_addr_q == $past(vec_base))
    else $error("pin reset not taken");
  a_uv_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    uv_low |=> state_q == CCS_ST_HOLD && st_q[ST_TO:ST_PD] == 2'b00)
    else $error("undervoltage reset not held");
  a_pend_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !soft_rst |=> (pend_q & $past(irq_event)) == $past(irq_event))
    else $error("interrupt event lost");
  a_wo_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == OP_WOSTORE
    |=> wo_plane_wr_q && wo_plane_addr_q == $past(ir_q[5:0]) && wo_plane_data_q == $past(w_q))
    else $error("write-only store wrong");
  a_iflag_one_instr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == OP_MISC && ir_q[2:0] == SUB_RETURN_FROM_INTERRUPT && !irq_event[0]
    |=> iflag_q [*2] ##1 (!iflag_q || core_reset_q))
    else $error("nesting block timing wrong");
  a_sub_no_borrow: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && op == OP_SUBWF |=> st_q[ST_C] == ($past(rd) >= $past(w_q)))
    else $error("subtract carry wrong");
  a_status_blocked: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec && (op == OP_ANDWF || op == OP_IORWF || op == OP_XORWF)
    && ir_q[7] && eff == FA_STATUS
    |=> st_q[ST_Z] == $past(alu_z) && st_q[ST_DC:ST_C] == $past(st_q[ST_DC:ST_C]))
    else $error("status write not blocked");
endmodule // ccs_core
`default_nettype wire

// ### src/ccs_pkg.sv
package ccs_pkg;
  localparam int PC_W = 10;
  localparam int STACK_DEPTH = 4;
  localparam int STACK_PTR_W = 2;
  localparam int RAM_DEPTH = 48;
  localparam logic [9:0] RESET_VEC = 10'h000;
  localparam logic [9:0] IRQ_VEC = 10'h001;
  localparam logic [9:0] REUSE_BASE = 10'h200;
  localparam logic [9:0] RESERVED_LO = 10'h3FD;
  localparam logic [13:0] CFG_RESET = 14'h3FFF;
  localparam int CFG_PROTECT = 13;
  localparam int CFG_REUSE = 12;
  localparam int CFG_UV_HI = 11;
  localparam int CFG_UV_LO = 10;
  localparam int CFG_XRST = 7;
  localparam logic [1:0] UV_2V1_ALWAYS = 2'h3;
  localparam logic [1:0] UV_2V1_RUN = 2'h2;
  localparam logic [1:0] UV_2V9 = 2'h1;
  localparam logic [1:0] UV_OFF = 2'h0;
  // file plane addresses
  localparam logic [6:0] FA_INDIRECT = 7'h00;
  localparam logic [6:0] FA_PC_LOW = 7'h02;
  localparam logic [6:0] FA_STATUS = 7'h03;
  localparam logic [6:0] FA_POINTER = 7'h04;
  localparam logic [6:0] FA_IRQ_PEND = 7'h0A;
  localparam logic [6:0] FA_IRQ_EN = 7'h0B;
  localparam logic [6:0] FA_RAM_LO = 7'h20;
  localparam logic [6:0] FA_RAM_HI = 7'h4F;
  // status bit positions
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;
  localparam int ST_Z = 2;
  localparam int ST_DC = 1;
  localparam int ST_C = 0;
  localparam logic [4:0] STATUS_RESET = 5'h00;
  // instruction word [13:10]
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_WOSTORE = 4'h1;
  localparam logic [3:0] OP_MOVWF = 4'h2;
  localparam logic [3:0] OP_MOVFW = 4'h3;
  localparam logic [3:0] OP_ADDWF = 4'h4;
  localparam logic [3:0] OP_SUBWF = 4'h5;
  localparam logic [3:0] OP_ANDWF = 4'h6;
  localparam logic [3:0] OP_IORWF = 4'h7;
  localparam logic [3:0] OP_JUMP = 4'h8;
  localparam logic [3:0] OP_CALL = 4'h9;
  localparam logic [3:0] OP_RETURN_WITH_LITERAL = 4'hA;
  localparam logic [3:0] OP_XORWF = 4'hB;
  localparam logic [3:0] OP_RRF = 4'hC;
  localparam logic [3:0] OP_RLF = 4'hD;
  localparam logic [3:0] OP_MOVLW = 4'hE;
  localparam logic [3:0] OP_ANDLW = 4'hF;
  // misc sub-op in [2:0]
  localparam logic [2:0] SUB_NOP = 3'h0;
  localparam logic [2:0] SUB_RET = 3'h1;
  localparam logic [2:0] SUB_RETURN_FROM_INTERRUPT = 3'h2;
  localparam logic [2:0] SUB_SLEEP = 3'h3;
  localparam logic [2:0] SUB_KICK = 3'h4;
  typedef enum logic [1:0] {
    CCS_ST_HOLD = 2'b10,
    CCS_ST_FETCH = 2'b00,
    CCS_ST_EXEC = 2'b01,
    CCS_ST_SLEEP = 2'b11
  } ccs_state_t;
  typedef enum logic [2:0] {
    CCS_ALU_ADD, CCS_ALU_SUB, CCS_ALU_AND, CCS_ALU_OR,
    CCS_ALU_XOR, CCS_ALU_RR, CCS_ALU_RL, CCS_ALU_PASS
  } ccs_alu_op_t;
endpackage

// ### src/ccs_alu.sv
`timescale 1ns/1ps
`default_nettype none
module ccs_alu
  import ccs_pkg::*;
(
  input wire ccs_alu_op_t op,
  input wire logic [7:0] w_in,
  input wire logic [7:0] b_in,
  input wire logic carry_in,
  output logic [7:0] res,
  output logic z,
  output logic dc,
  output logic c
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] wx;
  logic sub;
  always_comb
  begin
    sub = (op == CCS_ALU_SUB);
    // b minus w as b plus inverted w plus one, so carries mean no borrow
    wx = sub ? ~w_in : w_in;
    sum = {1'b0, b_in} + {1'b0, wx} + {8'h00, sub};
    nib = {1'b0, b_in[3:0]} + {1'b0, wx[3:0]} + {4'h0, sub};
    dc = nib[4];
    c = sum[8];
    unique case (op)
      CCS_ALU_ADD, CCS_ALU_SUB: res = sum[7:0];
      CCS_ALU_AND: res = b_in & w_in;
      CCS_ALU_OR: res = b_in | w_in;
      CCS_ALU_XOR: res = b_in ^ w_in;
      CCS_ALU_RR:
      begin
        res = {carry_in, b_in[7:1]};
        c = b_in[0];
      end
      CCS_ALU_RL:
      begin
        res = {b_in[6:0], carry_in};
        c = b_in[7];
      end
      CCS_ALU_PASS: res = b_in;
    endcase
    z = (res == 8'h00);
  end
endmodule // ccs_alu
`default_nettype wire

// ### src/ccs_stack.sv
`timescale 1ns/1ps
`default_nettype none
module ccs_stack
  import ccs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic pop,
  input wire logic [PC_W-1:0] push_addr,
  output logic [PC_W-1:0] top
);
  logic [PC_W-1:0] mem_q [STACK_DEPTH];
  logic [PC_W-1:0] mem_d [STACK_DEPTH];
  logic [STACK_PTR_W-1:0] ptr_q;
  logic [STACK_PTR_W-1:0] ptr_d;
  // pointer wraps, so a fifth push overwrites the oldest entry
  always_comb
  begin
    ptr_d = ptr_q;
    if (push)
      ptr_d = ptr_q + 2'h1;
    else if (pop)
      ptr_d = ptr_q - 2'h1;
  end
  for (genvar i = 0; i < STACK_DEPTH; i++)
  begin : g_entry
    always_comb
    begin
      mem_d[i] = (push && ptr_q == STACK_PTR_W'(i)) ? push_addr : mem_q[i];
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        mem_q[i] <= '0;
      else
        mem_q[i] <= mem_d[i];
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ptr_q <= '0;
    else
      ptr_q <= ptr_d;
  end
  assign top = mem_q[ptr_q - 2'h1];
endmodule // ccs_stack
`default_nettype wire

// ### verification/ccs_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccs_rom_model
  import ccs_pkg::*;
(
  input wire logic [PC_W-1:0] addr,
  output logic [13:0] data,
  output logic [13:0] cfg_out
);
  // contents are placed by the bench before reset is released
  logic [13:0] mem [0:1023];
  assign data = mem[addr];
  // one option word at 3FCh serves both halves
  assign cfg_out = mem[10'h3FC];
endmodule // ccs_rom_model
`default_nettype wire

// ### verification/cpu_core_sequencing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_sequencing_tb
  import ccs_pkg::*;
;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic port_a_bit_seven = 1'h1;
  logic supply_below_2v1 = 1'h0;
  logic supply_below_2v9 = 1'h0;
  logic watchdog_timeout = 1'h0;
  logic [7:0] irq_event = 8'h00;
  logic [PC_W-1:0] readout_addr = 10'h000;
  logic [PC_W-1:0] prog_addr_q;
  logic [13:0] rom_data;
  logic [13:0] config_word;
  logic readout_denied_q, wo_plane_wr_q, watchdog_clear_q, sleeping_q, pa7_gpio_q, core_reset_q;
  logic [5:0] wo_plane_addr_q;
  logic [7:0] wo_plane_data_q;
  logic [13:0] exp_q[$];
  logic [31:0] seed = 32'h21;
  logic [7:0] sf[5];
  logic [7:0] sw[5];
  logic [7:0] lit[4];
  int num_errors = 0;
  int n_compared = 0;
  int n_kick = 0;
  int ep;

  ccs_rom_model u_rom (.addr(prog_addr_q), .data(rom_data), .cfg_out(config_word));

  ccs_core u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .rom_data(rom_data), .prog_addr_q(prog_addr_q),
    .config_word(config_word), .port_a_bit_seven(port_a_bit_seven),
    .supply_below_2v1(supply_below_2v1), .supply_below_2v9(supply_below_2v9),
    .watchdog_timeout(watchdog_timeout), .irq_event(irq_event), .readout_addr(readout_addr),
    .readout_denied_q(readout_denied_q), .wo_plane_wr_q(wo_plane_wr_q),
    .wo_plane_addr_q(wo_plane_addr_q), .wo_plane_data_q(wo_plane_data_q),
    .watchdog_clear_q(watchdog_clear_q), .sleeping_q(sleeping_q), .pa7_gpio_q(pa7_gpio_q),
    .core_reset_q(core_reset_q)
  );

  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [13:0] fo(input logic [3:0] op, input logic d, input logic [6:0] a);
    return {op, 2'h0, d, a};
  endfunction

  function automatic logic [13:0] lw(input logic [7:0] x);
    return {OP_MOVLW, 2'h0, x};
  endfunction

  function automatic logic [13:0] wo(input logic [5:0] a);
    return {OP_WOSTORE, 4'h0, a};
  endfunction

  task put(input logic [13:0] w);
    u_rom.mem[ep] = w;
    ep++;
  endtask

  task cmp_wo(input logic [13:0] e, input logic [13:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: store %h expected %h", $time, g, e);
    end
  endtask

  task cmp_bit(input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: flag %b expected %b", $time, g, e);
    end
  endtask

  task conclude;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // program: vectors, indirect access, subtraction flags, status write, call and pc-low write
  task build;
    int i;
    for (i = 0; i < 1024; i++)
      u_rom.mem[i] = 14'h0000;
    u_rom.mem[10'h3FC] = 14'h1FFF;
    for (i = 0; i < 4; i++)
      lit[i] = rnd();
    sf = '{8'h05, 8'h03, 8'h10, rnd(), 8'h00};
    sw = '{8'h03, 8'h05, 8'h01, rnd(), 8'h00};
    sf[4] = rnd();
    sw[4] = sf[4];
    ep = 0;
    put({OP_JUMP, 10'h002});
    put({OP_JUMP, 10'h300});
    put(lw(8'h01));
    put(fo(OP_MOVWF, 1'h1, FA_IRQ_EN));
    put(lw(8'h25));
    put(fo(OP_MOVWF, 1'h1, FA_POINTER));
    put(lw(lit[0]));
    put(fo(OP_MOVWF, 1'h1, FA_INDIRECT));
    put(lw(8'h00));
    put(fo(OP_MOVFW, 1'h0, 7'h25));
    put(wo(6'h01));
    for (i = 0; i < 5; i++)
    begin
      put(lw(sf[i]));
      put(fo(OP_MOVWF, 1'h1, 7'h20));
      put(lw(sw[i]));
      put(fo(OP_SUBWF, 1'h0, 7'h20));
      put(wo(6'h02));
      put(fo(OP_MOVFW, 1'h0, FA_STATUS));
      put(wo(6'h03));
    end
    put(lw(8'hFF));
    put(fo(OP_MOVWF, 1'h1, FA_STATUS));
    put(fo(OP_MOVFW, 1'h0, FA_STATUS));
    put(wo(6'h04));
    // flag-only logic op on status: carry bits must survive the blocked write
    put(lw(8'h03));
    put(fo(OP_XORWF, 1'h1, FA_STATUS));
    put(fo(OP_MOVFW, 1'h0, FA_STATUS));
    put(wo(6'h05));
    put({OP_CALL, 10'h3A5});
    put(lw(lit[2]));
    put(wo(6'h08));
    put({OP_CALL, 10'h3C0});
    put(wo(6'h09));
    put({OP_JUMP, ep[9:0]});
    ep = 10'h3A5;
    put(lw(lit[1]));
    put(wo(6'h07));
    put(lw(8'hB0));
    put(fo(OP_MOVWF, 1'h1, FA_PC_LOW));
    ep = 10'h3B0;
    put({OP_MISC, 10'h001});
    ep = 10'h3C0;
    put({OP_RETURN_WITH_LITERAL, 2'h0, 8'h5A});
    ep = 10'h300;
    put(lw(8'h00));
    put(fo(OP_MOVWF, 1'h1, FA_IRQ_PEND));
    put(lw(lit[3]));
    put(wo(6'h10));
    // service routine sleeps until a second event, then kicks the watchdog
    put({OP_MISC, 10'h003});
    put({OP_MISC, 10'h004});
    put(lw(8'h00));
    put(fo(OP_MOVWF, 1'h1, FA_IRQ_PEND));
    put({OP_MISC, 10'h002});
  endtask

  task expect_pass(input logic t);
    int i;
    logic [7:0] d;
    exp_q.push_back({6'h01, lit[0]});
    for (i = 0; i < 5; i++)
    begin
      d = sf[i] - sw[i];
      exp_q.push_back({6'h02, d});
      exp_q.push_back({6'h03, 3'h0, t, 1'h0, d == 8'h00, sf[i][3:0] >= sw[i][3:0],
        sf[i] >= sw[i]});
    end
    exp_q.push_back({6'h04, 3'h0, t, 4'h7});
    exp_q.push_back({6'h05, 3'h0, t, 1'h0, !t, 2'h3});
    exp_q.push_back({6'h07, lit[1]});
    exp_q.push_back({6'h08, lit[2]});
    exp_q.push_back({6'h09, 8'h5A});
  endtask

  task wait_empty;
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < 3000)
    begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 3000)
    begin
      num_errors++;
      $display("wrong value at %0t: stores missing", $time);
    end
    repeat (8) @(posedge ref_clk);
  endtask

  task ro(input logic [9:0] a, input logic e);
    @(posedge ref_clk);
    readout_addr <= a;
    @(posedge ref_clk);
    @(negedge ref_clk);
    cmp_bit(e, readout_denied_q);
  endtask

  always @(posedge ref_clk)
  begin
    if (watchdog_clear_q === 1'h1)
      n_kick++;
    if (wo_plane_wr_q === 1'h1)
    begin
      if (exp_q.size() == 0)
      begin
        num_errors++;
        $display("wrong value at %0t: unexpected store", $time);
      end
      else
        cmp_wo(exp_q.pop_front(), {wo_plane_addr_q, wo_plane_data_q});
    end
  end

  initial
  begin
    #100000;
    num_errors++;
    conclude();
  end

  initial
  begin
    build();
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'h1;
    expect_pass(1'h0);
    wait_empty();
    ro(10'h1FF, 1'h1);
    ro(10'h200, 1'h0);
    cmp_bit(1'h1, pa7_gpio_q);
    exp_q.push_back({6'h10, lit[3]});
    @(posedge ref_clk);
    irq_event <= 8'h01;
    @(posedge ref_clk);
    irq_event <= 8'h00;
    wait_empty();
    @(negedge ref_clk);
    cmp_bit(1'h1, sleeping_q);
    @(posedge ref_clk);
    irq_event <= 8'h01;
    @(posedge ref_clk);
    irq_event <= 8'h00;
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    cmp_bit(1'h0, sleeping_q);
    cmp_bit(1'h1, n_kick == 1);
    expect_pass(1'h1);
    @(posedge ref_clk);
    watchdog_timeout <= 1'h1;
    @(posedge ref_clk);
    watchdog_timeout <= 1'h0;
    wait_empty();
    expect_pass(1'h1);
    @(posedge ref_clk);
    port_a_bit_seven <= 1'h0;
    repeat (4) @(posedge ref_clk);
    port_a_bit_seven <= 1'h1;
    wait_empty();
    expect_pass(1'h0);
    @(posedge ref_clk);
    supply_below_2v1 <= 1'h1;
    repeat (10) @(posedge ref_clk);
    @(negedge ref_clk);
    cmp_bit(1'h1, core_reset_q);
    @(posedge ref_clk);
    supply_below_2v1 <= 1'h0;
    wait_empty();
    // option word changes: reuse on, protect off, then gpio pin and no undervoltage
    u_rom.mem[10'h3FC] <= 14'h0FFF;
    repeat (2) @(posedge ref_clk);
    ro(10'h3FC, 1'h1);
    ro(10'h3FD, 1'h0);
    @(posedge ref_clk);
    u_rom.mem[10'h3FC] <= 14'h2FFF;
    repeat (2) @(posedge ref_clk);
    ro(10'h000, 1'h0);
    @(posedge ref_clk);
    u_rom.mem[10'h3FC] <= 14'h337F;
    repeat (2) @(posedge ref_clk);
    port_a_bit_seven <= 1'h0;
    supply_below_2v1 <= 1'h1;
    supply_below_2v9 <= 1'h1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    cmp_bit(1'h0, core_reset_q);
    cmp_bit(1'h0, pa7_gpio_q);
    @(posedge ref_clk);
    port_a_bit_seven <= 1'h1;
    supply_below_2v1 <= 1'h0;
    supply_below_2v9 <= 1'h0;
    u_rom.mem[10'h3FC] <= 14'h37FF;
    expect_pass(1'h0);
    repeat (2) @(posedge ref_clk);
    supply_below_2v9 <= 1'h1;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    cmp_bit(1'h1, core_reset_q);
    @(posedge ref_clk);
    supply_below_2v9 <= 1'h0;
    wait_empty();
    conclude();
  end
endmodule // cpu_core_sequencing_tb
`default_nettype wire
